/* File: verilog/slesr_consts.vh */
// Notes on behaviour
// - One status register holds the unexpected control-character error flag of each of the eight lanes, bit n for lane n.
// - A lane error flag reads 1 while that lane's error count is at or above the 8-bit threshold and 0 while it is below.
// - The invalid-code error flag of lane 0 sits at bit 0 of the invalid-code register and uses the same threshold test.
// - The code-group sync register holds one bit per lane, bit 7 for lane 7 and bit 6 for lane 6, 1 when sync is achieved and 0 when lost.
// - Reads return the status of the link chosen by the link page register, which software sets before reading.
// - All error flags and sync bits are read-only and read zero after reset until the receiver updates them or a zero threshold is written.
`ifndef SLESR_CONSTS_VH
`define SLESR_CONSTS_VH
`define SLESR_ADDR_W 12
`define SLESR_LANES 8
`define SLESR_LINKS 2
`define SLESR_OFF_LINK_PAGE 12'h0300
`define SLESR_OFF_THRESH 12'h0301
`define SLESR_OFF_CNT_CLR 12'h0302
`define SLESR_OFF_INVALID 12'h046E
`define SLESR_OFF_UNEXP 12'h046F
`define SLESR_OFF_SYNC 12'h0470
`define SLESR_OFF_IRQ_STAT 12'h0480
`define SLESR_OFF_IRQ_MASK 12'h0481
`define SLESR_RST_THRESH 8'h01
`define SLESR_RST_FLAGS 8'h00
`define SLESR_IRQ_UNEXP 0
`define SLESR_IRQ_INVALID 1
`define SLESR_IRQ_SYNC_LOST 2
`endif

/* File: verilog/slesr_err_counter.v */
`timescale 1ns/1ps
`default_nettype none
module slesr_err_counter (
  // Clock and reset.
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  // Control.
  input wire clear,
  input wire errEvent,
  input wire [7:0] threshold,
  // Result.
  output reg errFlag
);
  reg [7:0] count_r;
  wire [7:0] countNxt;

  // Saturation keeps the flag stable once a burst outruns the counter.
  assign countNxt = clear ? 8'h00 :
                    (errEvent && count_r != 8'hFF) ? count_r + 8'h01 : count_r;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 8'h00;
      errFlag <= 1'b0;
    end else if (clkEn) begin
      count_r <= countNxt;
      errFlag <= (countNxt >= threshold);
    end
  end
endmodule
`default_nettype wire

/* File: verilog/slesr_sync2.v */
`timescale 1ns/1ps
`default_nettype none
module slesr_sync2 #(
  parameter W = 8
) (
  // Clock and reset.
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  // Data.
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] meta_r;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else if (clkEn) begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/slesr_lane_status.v */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "slesr_consts.vh"
module slesr_lane_status (
  // Clock, reset and enable.
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  // Register port.
  input wire [11:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [7:0] regRdData,
  // Receiver events, one pulse per error, per link and lane.
  input wire [7:0] unexpCtrlErrLink0,
  input wire [7:0] unexpCtrlErrLink1,
  input wire [7:0] invalidCodeErrLink0,
  input wire [7:0] invalidCodeErrLink1,
  // Code-group sync levels from the lane aligners, asynchronous.
  input wire [7:0] groupSyncLink0,
  input wire [7:0] groupSyncLink1,
  // Interrupt.
  output reg irq
);
  // Registers.
  reg linkPage_r;
  reg [7:0] threshold_r;
  reg [7:0] irqStat_r;
  reg [7:0] irqMask_r;
  reg [7:0] irqStatNxt;
  reg [7:0] rdNxt;
  reg [7:0] unexpPrev_r;
  reg [7:0] invalidPrev_r;
  reg [7:0] syncPrev_r;
  reg [1:0] cntClr_r;

  wire [7:0] unexpFlags0;
  wire [7:0] unexpFlags1;
  wire [7:0] invalidFlags0;
  wire [7:0] invalidFlags1;
  wire [7:0] syncS0;
  wire [7:0] syncS1;
  wire [7:0] unexpSel;
  wire [7:0] invalidSel;
  wire [7:0] syncSel;
  wire [7:0] unexpAll;
  wire [7:0] invalidAll;
  wire [7:0] syncAll;

  function wrHit;
    input [11:0] a;
    input [11:0] off;
    begin
      wrHit = regWrEn && (a == off);
    end
  endfunction

  // One counter per lane, error type and link.
  genvar g;
  generate
    for (g = 0; g < `SLESR_LANES; g = g + 1) begin : lane
      slesr_err_counter uUnexp0 (
        .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .clear(cntClr_r[0]),
        .errEvent(unexpCtrlErrLink0[g]), .threshold(threshold_r),
        .errFlag(unexpFlags0[g]));
      slesr_err_counter uUnexp1 (
        .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .clear(cntClr_r[1]),
        .errEvent(unexpCtrlErrLink1[g]), .threshold(threshold_r),
        .errFlag(unexpFlags1[g]));
      slesr_err_counter uInv0 (
        .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .clear(cntClr_r[0]),
        .errEvent(invalidCodeErrLink0[g]), .threshold(threshold_r),
        .errFlag(invalidFlags0[g]));
      slesr_err_counter uInv1 (
        .clk(clk), .reset_n(reset_n), .clkEn(clkEn), .clear(cntClr_r[1]),
        .errEvent(invalidCodeErrLink1[g]), .threshold(threshold_r),
        .errFlag(invalidFlags1[g]));
    end
  endgenerate

  slesr_sync2 #(.W(8)) uSync0 (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .din(groupSyncLink0), .dout(syncS0));
  slesr_sync2 #(.W(8)) uSync1 (
    .clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .din(groupSyncLink1), .dout(syncS1));

  // Paged view for reads.
  assign unexpSel = linkPage_r ? unexpFlags1 : unexpFlags0;
  assign invalidSel = linkPage_r ? invalidFlags1 : invalidFlags0;
  assign syncSel = linkPage_r ? syncS1 : syncS0;

  // Interrupt sources cover both links so no event hides behind the page.
  assign unexpAll = unexpFlags0 | unexpFlags1;
  assign invalidAll = invalidFlags0 | invalidFlags1;
  assign syncAll = syncS0 & syncS1;

  // Control registers.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      linkPage_r <= 1'b0;
      threshold_r <= `SLESR_RST_THRESH;
      irqMask_r <= 8'h00;
      cntClr_r <= 2'b00;
    end else if (clkEn) begin
      cntClr_r <= 2'b00;
      if (wrHit(regAddr, `SLESR_OFF_LINK_PAGE)) begin
        linkPage_r <= regWrData[0];
      end
      if (wrHit(regAddr, `SLESR_OFF_THRESH)) begin
        threshold_r <= regWrData;
      end
      if (wrHit(regAddr, `SLESR_OFF_IRQ_MASK)) begin
        irqMask_r <= regWrData & 8'h07;
      end
      if (wrHit(regAddr, `SLESR_OFF_CNT_CLR)) begin
        cntClr_r <= regWrData[1:0];
      end
    end
  end

  // Sticky events: a new rising flag wins over a same-cycle clear.
  always @* begin
    irqStatNxt = irqStat_r;
    if (wrHit(regAddr, `SLESR_OFF_IRQ_STAT)) begin
      irqStatNxt = irqStatNxt & ~regWrData;
    end
    if (|(unexpAll & ~unexpPrev_r)) begin
      irqStatNxt[`SLESR_IRQ_UNEXP] = 1'b1;
    end
    if (|(invalidAll & ~invalidPrev_r)) begin
      irqStatNxt[`SLESR_IRQ_INVALID] = 1'b1;
    end
    if (|(~syncAll & syncPrev_r)) begin
      irqStatNxt[`SLESR_IRQ_SYNC_LOST] = 1'b1;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_r <= 8'h00;
      unexpPrev_r <= 8'h00;
      invalidPrev_r <= 8'h00;
      syncPrev_r <= 8'h00;
      irq <= 1'b0;
    end else if (clkEn) begin
      irqStat_r <= irqStatNxt;
      unexpPrev_r <= unexpAll;
      invalidPrev_r <= invalidAll;
      syncPrev_r <= syncAll;
      irq <= |(irqStatNxt & irqMask_r);
    end
  end

  // Read mux; the flag and sync registers ignore writes.
  always @* begin
    case (regAddr)
      `SLESR_OFF_LINK_PAGE: rdNxt = {7'h00, linkPage_r};
      `SLESR_OFF_THRESH: rdNxt = threshold_r;
      `SLESR_OFF_INVALID: rdNxt = invalidSel;
      `SLESR_OFF_UNEXP: rdNxt = unexpSel;
      `SLESR_OFF_SYNC: rdNxt = syncSel;
      `SLESR_OFF_IRQ_STAT: rdNxt = irqStat_r;
      `SLESR_OFF_IRQ_MASK: rdNxt = irqMask_r;
      default: rdNxt = 8'h00;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= `SLESR_RST_FLAGS;
    end else if (clkEn) begin
      regRdData <= regRdEn ? rdNxt : 8'h00;
    end
  end
endmodule
`default_nettype wire

/* File: dv/slesr_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module slesr_checker (
  // Register port and interrupt.
  input wire clk,
  input wire reset_n,
  input wire [11:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regRdData,
  input wire irq,
  // Sync levels.
  input wire [7:0] groupSyncLink0,
  input wire [7:0] groupSyncLink1
);
  logic [7:0] thr_r;
  logic [2:0] mask_r;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      thr_r <= 8'h01;
      mask_r <= 3'h0;
    end else begin
      if (regWrEn && regAddr == 12'h0301) thr_r <= regWrData;
      if (regWrEn && regAddr == 12'h0481) mask_r <= regWrData[2:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data outside slot");
  a_out_reset_zero: assert property (!$past(reset_n) |-> regRdData == 8'h00 && !irq)
    else $error("outputs not clear after reset");
  // Equal links make the page irrelevant; three stable samples cover the synchroniser.
  a_sync_follows: assert property (regRdEn && regAddr == 12'h0470 && $past(reset_n, 3)
    && groupSyncLink0 == groupSyncLink1 && $stable(groupSyncLink0)
    && $past(groupSyncLink0, 2) == groupSyncLink0 |=> regRdData == $past(groupSyncLink0))
    else $error("sync read wrong");
  a_thr_zero_unexp: assert property (regRdEn && regAddr == 12'h046F && thr_r == 8'h00
    && $past(thr_r) == 8'h00 |=> regRdData == 8'hFF)
    else $error("zero threshold flags");
  a_thr_zero_inval: assert property (regRdEn && regAddr == 12'h046E && thr_r == 8'h00
    && $past(thr_r) == 8'h00 |=> regRdData[0])
    else $error("zero threshold lane0 flag");
  a_irq_masked_off: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq)
    else $error("irq while masked");
  a_unmapped_zero: assert property (regRdEn && regAddr[11:8] == 4'h0 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  c_irq_high: cover property (irq);
  c_flag_read: cover property (regRdEn && regAddr == 12'h046F ##1 regRdData != 8'h00);
  c_irq_clear: cover property ($fell(irq));
endmodule
bind slesr_lane_status slesr_checker i_chk (.clk, .reset_n, .regAddr, .regWrData, .regWrEn,
  .regRdEn, .regRdData, .irq, .groupSyncLink0, .groupSyncLink1);
`default_nettype wire

/* File: dv/slesr_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module slesr_tx_model (
  // Clock.
  input wire logic clk,
  // Error pulses and sync levels.
  output var logic [7:0] u0,
  output var logic [7:0] n1,
  output var logic [7:0] s0,
  output var logic [7:0] s1
);
  initial {u0, n1, s0, s1} = 32'h0000_0000;
  // Lane i holds its line high for c[i] back-to-back cycles, one error per cycle; all lanes run in parallel.
  task automatic burst(input logic sel, input logic [7:0][2:0] c);
    logic [7:0] v;
    for (int k = 0; k < 9; k++) begin
      @(posedge clk);
      for (int i = 0; i < 8; i++) v[i] = c[i] > k;
      if (sel) n1 <= v;
      else u0 <= v;
    end
  endtask
  // Sync levels come from the lane clocks, so they move off our edge.
  task automatic sync(input logic [7:0] a, input logic [7:0] b);
    #3;
    s0 = a;
    s1 = b;
  endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] thr;
  logic [7:0] g;
  logic [7:0][2:0] c0;
  logic [7:0][2:0] c1;
  wire [7:0] regRdData, u0, n1, s0, s1;
  wire irq;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  slesr_tx_model i_tx (.clk, .u0, .n1, .s0, .s1);
  slesr_lane_status i_dut (.clk, .reset_n, .clkEn(1'b1), .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .unexpCtrlErrLink0(u0), .unexpCtrlErrLink1(8'h00),
    .invalidCodeErrLink0(8'h00), .invalidCodeErrLink1(n1), .groupSyncLink0(s0),
    .groupSyncLink1(s1), .irq);
  function automatic logic [7:0] flags(input logic [7:0][2:0] c, input logic [7:0] t);
    for (int i = 0; i < 8; i++) flags[i] = c[i] >= t;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(negedge clk);
    chk(regRdData, e);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #50000;
    fail_count++;
    close_out;
  end
  initial begin
    void'($urandom(32'heac5_b071));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(12'h046F, 8'h00);
    rd(12'h046E, 8'h00);
    rd(12'h0470, 8'h00);
    rd(12'h0042, 8'h00);
    thr = 8'h02 + 8'($urandom % 5);
    c0 = 24'($urandom);
    c1 = 24'($urandom);
    c0[0] = thr[2:0];
    c0[1] = thr[2:0] - 3'h1;
    c1[0] = 3'h7;
    wr(12'h0301, thr);
    fork
      i_tx.burst(1'b0, c0);
      i_tx.burst(1'b1, c1);
    join
    wr(12'h046F, 8'hFF);
    rd(12'h046F, flags(c0, thr));
    rd(12'h046E, 8'h00);
    wr(12'h0300, 8'h01);
    rd(12'h046E, flags(c1, thr));
    rd(12'h046F, 8'h00);
    wr(12'h0481, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(12'h0480, 8'h07);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    g = 8'($urandom);
    i_tx.sync(g, ~g);
    repeat (4) @(posedge clk);
    rd(12'h0470, ~g);
    wr(12'h0300, 8'h00);
    rd(12'h0470, g);
    i_tx.sync(8'hC0, 8'hC0);
    repeat (4) @(posedge clk);
    rd(12'h0470, 8'hC0);
    // Dropping sync on both links must latch only the sync-lost event bit.
    i_tx.sync(8'h00, 8'h00);
    repeat (4) @(posedge clk);
    rd(12'h0480, 8'h04);
    wr(12'h0301, 8'h00);
    rd(12'h046F, 8'hFF);
    wr(12'h0301, thr);
    wr(12'h0302, 8'h01);
    repeat (2) @(posedge clk);
    rd(12'h046F, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire
